// >>> src/scb_pkg.sv
// constants, register map and state type of the smbus configuration target
// assumes one system clock; smbus pins are already synchronous to it
package scb_pkg;
  // register indices
  localparam logic [7:0] SCB_IDX_OE_LO = 8'h00;
  localparam logic [7:0] SCB_IDX_OE_HI_SWING = 8'h01;
  localparam logic [7:0] SCB_IDX_EDGE_LO = 8'h02;
  localparam logic [7:0] SCB_IDX_EDGE_HI = 8'h03;
  localparam logic [7:0] SCB_IDX_RSVD_ONES = 8'h04;
  localparam logic [7:0] SCB_IDX_REV_VENDOR = 8'h05;
  localparam logic [7:0] SCB_IDX_TYPE_DEV = 8'h06;
  localparam logic [7:0] SCB_IDX_BYTE_COUNT = 8'h07;
  // field positions
  localparam int SCB_OE8_BIT = 5;
  localparam int SCB_EDGE8_BIT = 0;
  // reset values
  localparam logic [7:0] SCB_RST_OE_LO = 8'hFF;
  localparam logic SCB_RST_OE8 = 1'b1;
  localparam logic [1:0] SCB_RST_SWING = 2'h2;
  localparam logic [7:0] SCB_RST_EDGE_LO = 8'hFF;
  localparam logic SCB_RST_EDGE8 = 1'b1;
  localparam logic [4:0] SCB_RST_BYTE_COUNT = 5'h08;
  // fixed read values of reserved bits
  localparam logic [7:0] SCB_FIX_OE_HI = 8'h4C;
  localparam logic [7:0] SCB_FIX_RSVD_ONES = 8'hFF;
  // target addresses for the three strap levels
  localparam logic [6:0] SCB_ADDR_LOW = 7'h6B;
  localparam logic [6:0] SCB_ADDR_MID = 7'h6C;
  localparam logic [6:0] SCB_ADDR_HIGH = 7'h6D;
  // strap codes on the address select input
  localparam logic [1:0] SCB_STRAP_LOW = 2'h0;
  localparam logic [1:0] SCB_STRAP_MID = 2'h1;
  localparam logic [2:0] SCB_LAST_BIT = 3'h7;
  // transaction byte position for writes
  typedef enum logic [1:0] {SCB_POS_ADDR, SCB_POS_INDEX, SCB_POS_COUNT, SCB_POS_DATA} scb_pos_t;
  // bit level engine
  typedef enum logic [2:0] {SCB_ST_IDLE, SCB_ST_RX, SCB_ST_ACK_WAIT, SCB_ST_ACK, SCB_ST_TX,
                            SCB_ST_TX_ACK, SCB_ST_TX_NEXT} scb_state_t;
endpackage

// >>> src/scb_target.sv
// smbus target and configuration byte bank of a nine output clock buffer
// assumes scl/sda sampled on clk_sys_i, many system clocks per scl phase
//
// What this block does
// - target acks address, index, count, each data
// - read starts with byte count byte
// - then ascending registers, count from setting
// - target address latched from select strap
// - register 0 enables outputs 0..7, reset ones
// - register 1 bit 5 enables output 8
// - register 1 bits 1:0 select swing, reset 10
// - register 2 edge rate outputs 0..7, reset ones
// - register 3 bit 0 edge rate output 8
// - register 4 always reads all ones
// - register 7 bits 4:0 readback count, reset 8
// - registers 5,6 read-only identification bytes
`timescale 1ns/100ps
module scb_target
  import scb_pkg::*;
#(
  parameter int NUM_OUT = 9,
  parameter logic [3:0] REVISION_CODE = 4'hA, // arbitrary value
  parameter logic [3:0] VENDOR_CODE = 4'h5, // arbitrary value
  parameter logic [1:0] TYPE_CODE = 2'h2, // arbitrary value
  parameter logic [5:0] DEVICE_CODE = 6'h2A // arbitrary value
)(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [1:0] target_address_select_pin_i,
  input wire logic [NUM_OUT-1:0] output_enable_pin_n_i,
  output logic [NUM_OUT-1:0] clock_pair_run_o,
  output logic [NUM_OUT-1:0] edge_rate_select_o,
  output logic [1:0] swing_select_o
);
  import scb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  scb_state_t state, next_state;
  scb_pos_t pos, next_pos;
  logic scl_q, next_scl_q;
  logic sda_q, next_sda_q;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift;
  logic read_dir, next_read_dir;
  logic [4:0] remain, next_remain;
  logic [7:0] index, next_index;
  logic sda_drive, next_sda_drive;
  logic strap_done, next_strap_done;
  logic [6:0] own_addr, next_own_addr;
  logic [7:0] output_enable_bit, next_output_enable_bit;
  logic ninth_output_enable_bit, next_ninth_output_enable_bit;
  logic [1:0] swing, next_swing;
  logic [7:0] edge_rate_select_bit, next_edge_rate_select_bit;
  logic edge8, next_edge8;
  logic [4:0] readback_count_field, next_readback_count_field;
  logic [NUM_OUT-1:0] run, next_run;

  logic rise, fall, start_cond, stop_cond;
  logic [7:0] rd_byte, got_byte;

  ////////////////////////////////////////////////////////////////////////////
  // bus conditions seen against the previous sample
  assign rise = scl_i & ~scl_q;
  assign fall = ~scl_i & scl_q;
  assign start_cond = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_cond = scl_i & scl_q & ~sda_q & sda_i;
  assign got_byte = {shift[6:0], sda_i};

  // read mux; unmapped indices read zero
  always_comb
  begin
    case (index)
      SCB_IDX_OE_LO: rd_byte = output_enable_bit;
      SCB_IDX_OE_HI_SWING:
        rd_byte = SCB_FIX_OE_HI | {2'h0, ninth_output_enable_bit, 3'h0, swing};
      SCB_IDX_EDGE_LO: rd_byte = edge_rate_select_bit;
      SCB_IDX_EDGE_HI: rd_byte = {7'h0, edge8};
      SCB_IDX_RSVD_ONES: rd_byte = SCB_FIX_RSVD_ONES;
      SCB_IDX_REV_VENDOR: rd_byte = {REVISION_CODE, VENDOR_CODE};
      SCB_IDX_TYPE_DEV: rd_byte = {TYPE_CODE, DEVICE_CODE};
      SCB_IDX_BYTE_COUNT: rd_byte = {3'h0, readback_count_field};
      default: rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next values of protocol engine and register bank
  always_comb
  begin
    next_state = state;
    next_pos = pos;
    next_scl_q = scl_i;
    next_sda_q = sda_i;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_read_dir = read_dir;
    next_remain = remain;
    next_index = index;
    next_sda_drive = sda_drive;
    next_strap_done = 1'b1;
    next_own_addr = own_addr;
    next_output_enable_bit = output_enable_bit;
    next_ninth_output_enable_bit = ninth_output_enable_bit;
    next_swing = swing;
    next_edge_rate_select_bit = edge_rate_select_bit;
    next_edge8 = edge8;
    next_readback_count_field = readback_count_field;
    // strap caught once, on the first clock after reset release
    if (!strap_done)
    begin
      case (target_address_select_pin_i)
        SCB_STRAP_LOW: next_own_addr = SCB_ADDR_LOW;
        SCB_STRAP_MID: next_own_addr = SCB_ADDR_MID;
        default: next_own_addr = SCB_ADDR_HIGH;
      endcase
    end
    if (stop_cond)
    begin
      next_state = SCB_ST_IDLE;
      next_sda_drive = 1'b0;
    end
    else if (start_cond && strap_done)
    begin
      // also a repeated start; index is kept for the read that follows
      next_state = SCB_ST_RX;
      next_pos = SCB_POS_ADDR;
      next_bit_cnt = 3'h0;
      next_sda_drive = 1'b0;
    end
    else
    begin
      case (state)
        SCB_ST_IDLE: next_sda_drive = 1'b0;
        SCB_ST_RX:
        begin
          if (rise)
          begin
            next_shift = got_byte;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == SCB_LAST_BIT)
            begin
              next_state = SCB_ST_ACK_WAIT;
              case (pos)
                SCB_POS_ADDR:
                begin
                  next_read_dir = sda_i;
                  if (shift[6:0] != own_addr)
                    next_state = SCB_ST_IDLE; // not ours, stay silent
                  next_pos = SCB_POS_INDEX;
                end
                SCB_POS_INDEX:
                begin
                  next_index = got_byte;
                  next_pos = SCB_POS_COUNT;
                end
                SCB_POS_COUNT: next_pos = SCB_POS_DATA; // count only framed
                default:
                begin
                  case (index)
                    SCB_IDX_OE_LO: next_output_enable_bit = got_byte;
                    SCB_IDX_OE_HI_SWING:
                    begin
                      next_ninth_output_enable_bit = got_byte[SCB_OE8_BIT];
                      next_swing = got_byte[1:0];
                    end
                    SCB_IDX_EDGE_LO: next_edge_rate_select_bit = got_byte;
                    SCB_IDX_EDGE_HI: next_edge8 = got_byte[SCB_EDGE8_BIT];
                    SCB_IDX_BYTE_COUNT: next_readback_count_field = got_byte[4:0];
                    default: next_index = index;
                  endcase
                  next_index = index + 8'h01;
                end
              endcase
            end
          end
        end
        SCB_ST_ACK_WAIT:
        begin
          if (fall)
          begin
            next_sda_drive = 1'b1;
            next_state = SCB_ST_ACK;
          end
        end
        SCB_ST_ACK:
        begin
          if (fall)
          begin
            next_bit_cnt = 3'h0;
            if (read_dir && pos == SCB_POS_INDEX)
            begin
              // count byte goes first
              next_shift = {3'h0, readback_count_field};
              next_remain = readback_count_field;
              next_sda_drive = 1'b1; // top three bits of the count are zero
              next_state = SCB_ST_TX;
            end
            else
            begin
              next_sda_drive = 1'b0;
              next_state = SCB_ST_RX;
            end
          end
        end
        SCB_ST_TX:
        begin
          if (fall)
          begin
            next_bit_cnt = bit_cnt + 3'h1;
            next_shift = {shift[6:0], 1'b1};
            if (bit_cnt == SCB_LAST_BIT)
            begin
              next_sda_drive = 1'b0; // release for host answer
              next_state = SCB_ST_TX_ACK;
            end
            else
              next_sda_drive = ~shift[6];
          end
        end
        SCB_ST_TX_ACK:
        begin
          if (rise)
            next_state = sda_i ? SCB_ST_IDLE : SCB_ST_TX_NEXT;
        end
        SCB_ST_TX_NEXT:
        begin
          // host acked
          if (fall)
          begin
            next_bit_cnt = 3'h0;
            next_state = SCB_ST_TX;
            if (remain != 5'h00)
            begin
              // ascending bytes up to the programmed count
              next_shift = rd_byte;
              next_sda_drive = ~rd_byte[7];
              next_remain = remain - 5'h01;
              next_index = index + 8'h01;
            end
            else
            begin
              // past the count the line is left released and reads ones
              next_shift = SCB_FIX_RSVD_ONES;
              next_sda_drive = 1'b0;
            end
          end
        end
        default: next_state = SCB_ST_IDLE;
      endcase
    end
  end

  // pair runs only with bit set and active low pin asserted
  always_comb
  begin
    next_run = {ninth_output_enable_bit, output_enable_bit}
             & ~output_enable_pin_n_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers only
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state <= SCB_ST_IDLE;
      pos <= SCB_POS_ADDR;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      read_dir <= 1'b0;
      remain <= 5'h00;
      index <= 8'h00;
      sda_drive <= 1'b0;
      strap_done <= 1'b0;
      own_addr <= SCB_ADDR_HIGH;
      output_enable_bit <= SCB_RST_OE_LO;
      ninth_output_enable_bit <= SCB_RST_OE8;
      swing <= SCB_RST_SWING;
      edge_rate_select_bit <= SCB_RST_EDGE_LO;
      edge8 <= SCB_RST_EDGE8;
      readback_count_field <= SCB_RST_BYTE_COUNT;
      run <= '0;
    end
    else
    begin
      state <= next_state;
      pos <= next_pos;
      scl_q <= next_scl_q;
      sda_q <= next_sda_q;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      read_dir <= next_read_dir;
      remain <= next_remain;
      index <= next_index;
      sda_drive <= next_sda_drive;
      strap_done <= next_strap_done;
      own_addr <= next_own_addr;
      output_enable_bit <= next_output_enable_bit;
      ninth_output_enable_bit <= next_ninth_output_enable_bit;
      swing <= next_swing;
      edge_rate_select_bit <= next_edge_rate_select_bit;
      edge8 <= next_edge8;
      readback_count_field <= next_readback_count_field;
      run <= next_run;
    end
  end

  // open drain: only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_drive;
  assign clock_pair_run_o = run;
  assign edge_rate_select_o = {edge8, edge_rate_select_bit};
  assign swing_select_o = swing;
endmodule

// >>> testbench/scb_target_assertions.sv
// checker for the smbus configuration target
// assumes bind to scb_target, smbus pins synchronous to clk_sys_i
`timescale 1ns/100ps
module scb_target_assertions
  import scb_pkg::*;
#(
  parameter int NUM_OUT = 9
)(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [1:0] target_address_select_pin_i,
  input wire logic [NUM_OUT-1:0] output_enable_pin_n_i,
  input wire logic [NUM_OUT-1:0] clock_pair_run_o,
  input wire logic [NUM_OUT-1:0] edge_rate_select_o,
  input wire logic [1:0] swing_select_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////////////////////////////
  // open drain only ever pulls low
  a_data_open_drain: assert property (sda_o == 1'b0)
    else $error("data value not low");
  // ack and data may only move one clock after scl fell
  a_pull_after_fall: assert property ($rose(sda_oe_o) |-> !$past(scl_i) && $past(scl_i, 2))
    else $error("data pull began off the scl fall");
  a_free_after_fall: assert property ($fell(sda_oe_o) |-> !$past(scl_i) && $past(scl_i, 2))
    else $error("data release off the scl fall");
  a_steady_scl_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("data moved while scl high");
  // a high pin must hold its pair low whatever the enable bit
  a_pin_gates_run: assert property ((clock_pair_run_o & $past(output_enable_pin_n_i)) == '0)
    else $error("pair runs with its pin high");
  a_reset_values: assert property ($rose(arst_n_i) |->
      edge_rate_select_o == {NUM_OUT{1'b1}} && swing_select_o == SCB_RST_SWING)
    else $error("edge or swing reset value wrong");
  a_run_from_reset: assert property ($rose(arst_n_i) |->
      ##2 clock_pair_run_o == ~$past(output_enable_pin_n_i))
    else $error("pairs not enabled after reset");
  // register writes land at an scl rise, never while scl is low
  a_swing_on_rise: assert property ($changed(swing_select_o) |-> scl_i)
    else $error("swing changed while scl low");
  a_edge_on_rise: assert property ($changed(edge_rate_select_o) |-> scl_i)
    else $error("edge rate changed while scl low");
  c_ack: cover property ($rose(sda_oe_o));
  c_swing: cover property ($changed(swing_select_o));
  c_run_off: cover property ($fell(clock_pair_run_o[0]));
endmodule
bind scb_target scb_target_assertions #(.NUM_OUT(NUM_OUT)) chk_u (.clk_sys_i, .arst_n_i,
  .scl_i, .sda_i, .sda_o, .sda_oe_o, .target_address_select_pin_i, .output_enable_pin_n_i,
  .clock_pair_run_o, .edge_rate_select_o, .swing_select_o);

// >>> testbench/scb_host_model.sv
// smbus host model, drives scl and releases or pulls data
// assumes a pulled-up data wire resolved by the bench
`timescale 1ns/100ps
module scb_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // idle bus: both lines released high
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // start or repeated start: data falls while scl high
  task automatic start();
    sda_o = 1'b1;
    wt(3);
    scl_o = 1'b1;
    wt(3);
    sda_o = 1'b0;
    wt(3);
    scl_o = 1'b0;
  endtask
  // stop: data rises while scl high
  task automatic stop();
    wt(2);
    sda_o = 1'b0;
    wt(3);
    scl_o = 1'b1;
    wt(3);
    sda_o = 1'b1;
    wt(3);
  endtask
  // data set mid low phase, sampled just before scl falls
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    sda_o = b;
    wt(3);
    scl_o = 1'b1;
    wt(4);
    r = sda_i;
    scl_o = 1'b0;
  endtask
  // msb first, then the ack slot; tx of ff releases for reading
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic acked);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], b);
      rx[i] = b;
    end
    bit_io(ack_in, b);
    acked = ~b;
  endtask
endmodule

// >>> testbench/testbench.sv
// self-checking bench for the smbus configuration target
// assumes the host model and the bound checker
`timescale 1ns/100ps
module testbench;
  import scb_pkg::*;
  logic clk_sys_i, arst_n_i, scl_i, sda_i, host_sda, sda_o, sda_oe_o, ok;
  logic [1:0] target_address_select_pin_i, swing_select_o;
  logic [8:0] output_enable_pin_n_i, clock_pair_run_o, edge_rate_select_o;
  logic [7:0] q [6];
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  // wired-and data line with pull-up
  assign sda_i = host_sda & (sda_o | ~sda_oe_o);
  scb_target dut_u (.clk_sys_i, .arst_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
    .target_address_select_pin_i, .output_enable_pin_n_i, .clock_pair_run_o,
    .edge_rate_select_o, .swing_select_o);
  scb_host_model host_u (.clk_i(clk_sys_i), .sda_i(sda_i), .scl_o(scl_i), .sda_o(host_sda));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // indexed block write of n bytes taken msb first from d
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, input int n,
                    input logic [31:0] d);
    logic [7:0] rx;
    logic ak;
    host_u.start();
    host_u.xfer({a, 1'b0}, 1'b1, rx, ak);
    ok = ak;
    host_u.xfer(idx, 1'b1, rx, ak);
    ok &= ak;
    host_u.xfer(8'(n), 1'b1, rx, ak);
    ok &= ak;
    for (int i = 0; i < n; i++)
    begin
      host_u.xfer(d[31-8*i -: 8], 1'b1, rx, ak);
      ok &= ak;
    end
    host_u.stop();
  endtask
  // indexed block read: q[0] is the count byte, then n registers
  task automatic rd(input logic [7:0] idx, input int n);
    logic [7:0] rx;
    logic ak;
    host_u.start();
    host_u.xfer({SCB_ADDR_LOW, 1'b0}, 1'b1, rx, ak);
    ok = ak;
    host_u.xfer(idx, 1'b1, rx, ak);
    ok &= ak;
    host_u.start();
    host_u.xfer({SCB_ADDR_LOW, 1'b1}, 1'b1, rx, ak);
    ok &= ak;
    for (int i = 0; i <= n; i++)
      host_u.xfer(8'hFF, 1'(i == n), q[i], ak);
    host_u.stop();
  endtask
  // compare q[1..5] with five packed bytes
  task automatic check5(input logic [39:0] e);
    for (int i = 1; i <= 5; i++)
      check(9'(q[i]), 9'(e[47-8*i -: 8]));
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check(edge_rate_select_o, 9'h1FF);
    check(9'(swing_select_o), 9'h002);
    check(clock_pair_run_o, 9'h1FF);
    $display("test reset done");
  endtask
  task automatic t_write_read();
    wr(SCB_ADDR_LOW, 8'h00, 4, 32'h00010F00);
    check(9'(ok), 9'h001);
    check(clock_pair_run_o, 9'h000);
    check(9'(swing_select_o), 9'h001);
    check(edge_rate_select_o, 9'h00F);
    wr(SCB_ADDR_LOW, 8'h07, 1, 32'h05000000);
    rd(8'h00, 5);
    check(9'(ok), 9'h001);
    check(9'(q[0]), 9'h005);
    check5(40'h004D0F00FF);
    // writes to fixed bytes must leave them untouched
    wr(SCB_ADDR_LOW, 8'h04, 3, 32'h00000000);
    rd(8'h04, 5);
    check5(40'hFFA5AA0500);
    $display("test write read done");
  endtask
  task automatic t_addr();
    // strap moved after reset: the latched address must not follow it
    target_address_select_pin_i = SCB_STRAP_MID;
    wr(SCB_ADDR_MID, 8'h02, 1, 32'h0);
    check(9'(ok), 9'h000);
    check(edge_rate_select_o, 9'h00F);
    wr(SCB_ADDR_LOW, 8'h07, 1, 32'h05000000);
    check(9'(ok), 9'h001);
    target_address_select_pin_i = SCB_STRAP_LOW;
    $display("test address done");
  endtask
  task automatic t_swing_pins();
    for (int s = 0; s < 4; s++)
    begin
      wr(SCB_ADDR_LOW, 8'h00, 2, {8'hFF, 6'h08, 2'(s), 16'h0});
      check(9'(swing_select_o), 9'(s));
    end
    output_enable_pin_n_i = 9'h0A5;
    repeat (3) @(negedge clk_sys_i);
    check(clock_pair_run_o, 9'h15A);
    $display("test swing pins done");
  endtask
  ////////////////////////////////////////////////////////////////
  // clock source
  initial
  begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // hang guard, well above the expected run length
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      mismatches++;
      summarize();
    end
  end
  // main sequence
  initial
  begin
    arst_n_i = 1'b0;
    output_enable_pin_n_i = '0;
    target_address_select_pin_i = SCB_STRAP_LOW;
    repeat (6) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    t_reset();
    t_write_read();
    t_addr();
    t_swing_pins();
    summarize();
  end
endmodule
